/* File: rtl/fan_ctl_regs.vh */
`ifndef FAN_CTL_REGS_VH
`define FAN_CTL_REGS_VH

// Register addresses
`define ADDR_MAKER_CODE 8'h3e
`define ADDR_REV_CODE 8'h3f
`define ADDR_CTRL 8'h40

// Span of the limit and parameter block
`define ADDR_LIMIT_FIRST 8'h5c
`define ADDR_LIMIT_LAST 8'h6e

// Control register field positions
`define CTRL_START_BIT 0
`define CTRL_LOCK_BIT 1
`define CTRL_READY_BIT 2
`define CTRL_FORCE_BIT 3

// Reset values
`define CTRL_RESET 8'h00
`define RDATA_RESET 8'h00
`define DUTY_RESET 8'h00
`define LIMIT_FWD_RESET 8'h00

// Duty codes
`define DUTY_FULL 8'hff
`define DUTY_OFF 8'h00

// Power-up settle time before ready may rise
`define SETTLE_NS 1000
`define CLK_PERIOD_NS 10
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CNT_W 8

`endif

/* File: rtl/monitor_id_and_fan_start_lock.v */
`timescale 1ns/1ps
`default_nettype none
`include "fan_ctl_regs.vh"

// How it works
// - Fixed maker code readable at 3Eh
// - Writes to identification registers are ignored
// - Revision: stepping low nibble, device number high
// - Stepping bit 3 always reads one
// - Start set: programmed limits and parameters used
// - Start clear: built-in defaults are used
// - Start never alters stored limit values
// - Start stays writable even when locked
// - Lock blocks limit writes until power-off
// - Lock bit sticks at one once set
// - Ready rises itself after power-up, converters good
// - Force bit drives every PWM to full duty
// - Force beats a channel's disabled mode
module monitor_id_and_fan_start_lock #(
    // Maker code; value arbitrary
    parameter [7:0] MAKER_CODE = 8'h5a,
    // Base device number; value arbitrary
    parameter [3:0] BASE_DEVICE = 4'h3,
    // Low three stepping bits; value arbitrary
    parameter [2:0] STEPPING_LOW = 3'h2
) (
    // Clock and power-on reset
    input wire i_clk,
    input wire i_rst,
    // Register access from the serial bus engine
    input wire [7:0] i_reg_addr,
    input wire i_reg_wr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_rd,
    output wire [7:0] o_reg_rdata,
    output wire o_reg_rvalid,
    // Converter health, asynchronous
    input wire i_adc_ok,
    // Gated writes toward the limit block
    output wire o_limit_wr,
    output wire [7:0] o_limit_addr,
    output wire [7:0] o_limit_wdata,
    // Control levels toward fan logic
    output wire o_use_programmed,
    output wire o_limits_locked,
    output wire o_ready,
    output wire o_force_full_duty,
    // Per-channel duty from the auto controller
    input wire [23:0] i_auto_duty,
    input wire [2:0] i_pwm_disabled,
    // Final per-channel duty to PWM generators
    output wire [23:0] o_pwm_duty
);

    // Address falls in the lockable limit span
    function is_limit_addr;
        input [7:0] addr;
        begin
            is_limit_addr = (addr >= `ADDR_LIMIT_FIRST) &&
                            (addr <= `ADDR_LIMIT_LAST);
        end
    endfunction

    // Address hits the control register
    function is_ctrl_addr;
        input [7:0] addr;
        begin
            is_ctrl_addr = (addr == `ADDR_CTRL);
        end
    endfunction

    // Reset image of the control register
    localparam [7:0] CTRL_INIT = `CTRL_RESET;
    // Settle terminal count, cut to counter width
    localparam integer SETTLE_CYC_INT = `SETTLE_CYCLES;
    localparam [`SETTLE_CNT_W-1:0] SETTLE_END = SETTLE_CYC_INT[`SETTLE_CNT_W-1:0];

    // Fixed revision byte, stepping top bit forced high
    wire [7:0] rev_code;
    assign rev_code = {BASE_DEVICE, 1'b1, STEPPING_LOW};

    // Control register bits
    reg start_r; // Programmed-set select
    reg lock_r; // Sticky limit lock
    reg ready_r; // Power-up complete flag
    reg force_r; // Full duty override

    // Next values for control bits
    reg start_nxt;
    reg lock_nxt;
    reg force_nxt;

    // Converter health synchroniser
    reg adc_ok_meta_r; // First stage, read only by second
    reg adc_ok_sync_r; // Safe to use

    // Settle counter after reset release
    reg [`SETTLE_CNT_W-1:0] settle_cnt_r;
    wire settle_done;

    // Read path
    reg [7:0] rdata_r;
    reg [7:0] rdata_nxt;
    reg rvalid_r;

    // Gated limit write path
    reg limit_wr_r;
    reg [7:0] limit_addr_r;
    reg [7:0] limit_wdata_r;

    // Decoded strobes
    wire ctrl_wr;
    wire limit_wr_ok;

    assign ctrl_wr = i_reg_wr && is_ctrl_addr(i_reg_addr);
    // Lock drops every write into the limit span
    assign limit_wr_ok = i_reg_wr && is_limit_addr(i_reg_addr) && !lock_r;

    // Settle count reached
    assign settle_done = (settle_cnt_r == SETTLE_END);

    // Control register write decode
    always @*
    begin
        start_nxt = start_r;
        lock_nxt = lock_r;
        force_nxt = force_r;
        if (ctrl_wr)
        begin
            // Start writable whatever the lock holds
            start_nxt = i_reg_wdata[`CTRL_START_BIT];
            // Lock only ever goes from zero to one
            lock_nxt = lock_r | i_reg_wdata[`CTRL_LOCK_BIT];
            force_nxt = i_reg_wdata[`CTRL_FORCE_BIT];
            // Ready and upper bits are not writable
        end
    end

    // Control register flops
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            start_r <= CTRL_INIT[`CTRL_START_BIT];
            lock_r <= CTRL_INIT[`CTRL_LOCK_BIT];
            force_r <= CTRL_INIT[`CTRL_FORCE_BIT];
        end
        else
        begin
            start_r <= start_nxt;
            lock_r <= lock_nxt;
            force_r <= force_nxt;
        end
    end

    // Two-stage sync of converter health
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            adc_ok_meta_r <= 1'b0;
            adc_ok_sync_r <= 1'b0;
        end
        else
        begin
            adc_ok_meta_r <= i_adc_ok;
            adc_ok_sync_r <= adc_ok_meta_r;
        end
    end

    // Settle counter, stops at terminal count
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            settle_cnt_r <= {`SETTLE_CNT_W{1'b0}};
        end
        else if (!settle_done)
        begin
            settle_cnt_r <= settle_cnt_r + {{(`SETTLE_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Ready rises once, after settle and good converters
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ready_r <= CTRL_INIT[`CTRL_READY_BIT];
        end
        else if (settle_done && adc_ok_sync_r)
        begin
            ready_r <= 1'b1;
        end
    end

    // Read data mux
    always @*
    begin
        case (i_reg_addr)
            `ADDR_MAKER_CODE:
            begin
                rdata_nxt = MAKER_CODE;
            end
            `ADDR_REV_CODE:
            begin
                rdata_nxt = rev_code;
            end
            `ADDR_CTRL:
            begin
                // Upper nibble always zero
                rdata_nxt = 8'h00;
                rdata_nxt[`CTRL_START_BIT] = start_r;
                rdata_nxt[`CTRL_LOCK_BIT] = lock_r;
                rdata_nxt[`CTRL_READY_BIT] = ready_r;
                rdata_nxt[`CTRL_FORCE_BIT] = force_r;
            end
            default:
            begin
                // Unmapped here reads zero
                rdata_nxt = `RDATA_RESET;
            end
        endcase
    end

    // Read answer, one cycle after the strobe
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            rdata_r <= `RDATA_RESET;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= i_reg_rd;
            if (i_reg_rd)
            begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // Forward unlocked limit writes; ID writes go nowhere
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            limit_wr_r <= 1'b0;
            limit_addr_r <= `LIMIT_FWD_RESET;
            limit_wdata_r <= `LIMIT_FWD_RESET;
        end
        else
        begin
            // Start changes never reach the limit block
            limit_wr_r <= limit_wr_ok;
            if (limit_wr_ok)
            begin
                limit_addr_r <= i_reg_addr;
                limit_wdata_r <= i_reg_wdata;
            end
        end
    end

    // Per-channel duty override
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1)
        begin : g_pwm
            reg [7:0] duty_r;
            always @(posedge i_clk)
            begin
                if (i_rst)
                begin
                    duty_r <= `DUTY_RESET;
                end
                else if (force_r)
                begin
                    // Override wins over disabled and auto
                    duty_r <= `DUTY_FULL;
                end
                else if (i_pwm_disabled[ch])
                begin
                    // Disabled channel idles
                    duty_r <= `DUTY_OFF;
                end
                else
                begin
                    // Auto controller value
                    duty_r <= i_auto_duty[ch*8 +: 8];
                end
            end
            assign o_pwm_duty[ch*8 +: 8] = duty_r;
        end
    endgenerate

    // Outputs straight from flops
    assign o_reg_rdata = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_limit_wr = limit_wr_r;
    assign o_limit_addr = limit_addr_r;
    assign o_limit_wdata = limit_wdata_r;
    // Fan logic picks programmed or default set
    assign o_use_programmed = start_r;
    assign o_limits_locked = lock_r;
    assign o_ready = ready_r;
    assign o_force_full_duty = force_r;

endmodule

`default_nettype wire

/* File: testbench/fan_ctl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module fan_ctl_properties #(
    parameter [7:0] MAKER_CODE = 8'h00
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register bus
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    // Fan side
    input wire logic o_limit_wr,
    input wire logic [7:0] o_limit_addr,
    input wire logic o_use_programmed,
    input wire logic o_limits_locked,
    input wire logic o_ready,
    input wire logic o_force_full_duty,
    input wire logic [23:0] o_pwm_duty
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Read answers and fixed contents
    read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid) else $error("no read answer");
    maker_fixed_a: assert property (i_reg_rd && i_reg_addr == 8'h3e |=> o_reg_rdata == MAKER_CODE)
        else $error("maker code read wrong");
    rev_bit_a: assert property (i_reg_rd && i_reg_addr == 8'h3f |=> o_reg_rdata[3]) else $error("rev bit");
    upper_zero_a: assert property (i_reg_rd && i_reg_addr == 8'h40 |=> o_reg_rdata[7:4] == 4'h0)
        else $error("upper control bits not zero");
    // Start and lock
    start_write_a: assert property (i_reg_wr && i_reg_addr == 8'h40 |=>
        o_use_programmed == $past(i_reg_wdata[0])) else $error("start bit not taken");
    lock_sticky_a: assert property (o_limits_locked |=> o_limits_locked) else $error("lock lost");
    locked_no_fwd_a: assert property (o_limits_locked |=> !o_limit_wr) else $error("locked write passed");
    fwd_span_a: assert property (o_limit_wr |-> o_limit_addr >= 8'h5c && o_limit_addr <= 8'h6e)
        else $error("forwarded write outside span");
    // Ready and forced duty
    ready_reset_a: assert property (disable iff (1'b0) i_rst |=> !o_ready) else $error("ready early");
    force_full_a: assert property (o_force_full_duty |=> o_pwm_duty == 24'hffffff)
        else $error("force duty");
endmodule
bind monitor_id_and_fan_start_lock fan_ctl_properties #(.MAKER_CODE(MAKER_CODE)) chk (.i_clk, .i_rst, .i_reg_addr,
    .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .o_limit_wr, .o_limit_addr, .o_use_programmed,
    .o_limits_locked, .o_ready, .o_force_full_duty, .o_pwm_duty);
`default_nettype wire

/* File: testbench/fan_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fan_side_model (
    // Clock
    input wire logic i_clk,
    // Auto duty and converter health
    output wire logic [23:0] o_auto_duty,
    output logic o_adc_ok
);
    logic [6:0] cnt = 7'h00; // Pattern changes every cycle
    initial o_adc_ok = 1'b0;
    // Converters come good after a few cycles, off the sampling edge
    always @(negedge i_clk)
    begin
        cnt <= cnt + 7'h01;
        if (cnt == 7'h08)
            o_adc_ok <= 1'b1;
    end
    // Never full scale, so forced duty is told apart
    assign o_auto_duty = {3{1'b0, cnt}};
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fan_ctl_regs.vh"
`define CHK(a,b) begin compares++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
    logic i_clk = 1'b0; // Bench clock
    logic i_rst = 1'b1; // Power-on reset
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [2:0] dis = 3'h0; // Disabled channels
    logic [7:0] rdata, q, laddr, lwdata;
    logic rvalid, lwr, start, lock, ready, force_on, adc_ok;
    logic [23:0] auto, duty;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    always #5 i_clk = ~i_clk;
    monitor_id_and_fan_start_lock #(.MAKER_CODE(8'h5a), .BASE_DEVICE(4'h3), .STEPPING_LOW(3'h2)) uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_adc_ok(adc_ok), .o_limit_wr(lwr), .o_limit_addr(laddr),
        .o_limit_wdata(lwdata), .o_use_programmed(start), .o_limits_locked(lock), .o_ready(ready),
        .o_force_full_duty(force_on), .i_auto_duty(auto), .i_pwm_disabled(dis), .o_pwm_duty(duty));
    fan_side_model model (.i_clk(i_clk), .o_auto_duty(auto), .o_adc_ok(adc_ok));
    // One write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge i_clk);
        wr = 1'b0;
    endtask
    // One read strobe, answer taken a cycle later
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        addr = a;
        rd = 1'b1;
        @(negedge i_clk);
        rd = 1'b0;
        d = rdata;
        `CHK(rvalid, 1'b1)
    endtask
    // Ready rises late by itself; read-only bits hold
    task automatic t_ready;
        int n;
        rd_reg(`ADDR_CTRL, q);
        `CHK(q, 8'h00)
        for (n = 0; n < 300 && ready !== 1'b1; n++)
            @(negedge i_clk);
        `CHK(ready, 1'b1)
        `CHK(n > 90, 1'b1)
        wr_reg(`ADDR_CTRL, 8'hf0);
        rd_reg(`ADDR_CTRL, q);
        `CHK(q, 8'h04)
    endtask
    // Identification stays fixed under writes
    task automatic t_ids;
        wr_reg(`ADDR_MAKER_CODE, 8'ha5);
        wr_reg(`ADDR_REV_CODE, 8'h00);
        rd_reg(`ADDR_MAKER_CODE, q);
        `CHK(q, 8'h5a)
        rd_reg(`ADDR_REV_CODE, q);
        `CHK(q, {4'h3, 1'b1, 3'h2})
    endtask
    // Start, lock and gated limit writes
    task automatic t_lock;
        wr_reg(`ADDR_LIMIT_FIRST, 8'h3c);
        `CHK({lwr, laddr, lwdata, start}, {1'b1, 8'h5c, 8'h3c, 1'b0})
        wr_reg(`ADDR_CTRL, 8'h01);
        `CHK({start, lwr}, 2'b10)
        wr_reg(`ADDR_CTRL, 8'h03);
        wr_reg(`ADDR_LIMIT_LAST, 8'h77);
        `CHK(lwr, 1'b0)
        wr_reg(`ADDR_CTRL, 8'h00);
        `CHK({lock, start}, 2'b10)
        wr_reg(`ADDR_CTRL, 8'h01);
        rd_reg(`ADDR_CTRL, q);
        `CHK(q, 8'h07)
    endtask
    // Forced duty beats disabled mode
    task automatic t_force;
        @(negedge i_clk);
        dis = 3'h7;
        repeat (2) @(negedge i_clk);
        `CHK(duty, 24'h000000)
        wr_reg(`ADDR_CTRL, 8'h0b);
        @(negedge i_clk);
        `CHK(duty, 24'hffffff)
        dis = 3'h0;
        repeat (2) @(negedge i_clk);
        `CHK({force_on, duty}, {1'b1, 24'hffffff})
        wr_reg(`ADDR_CTRL, 8'h03);
        @(negedge i_clk);
        `CHK(duty !== 24'hffffff, 1'b1)
    endtask
    task automatic end_of_test;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            failures++;
            end_of_test();
        end
    end
    // Main sequence
    initial
    begin
        repeat (16) @(negedge i_clk);
        i_rst = 1'b0;
        t_ready();
        t_ids();
        t_lock();
        t_force();
        end_of_test();
    end
endmodule
`default_nettype wire
